/* uart_pkg.sv */
// Overview of operation
// - Mode 1 frame: start, eight LSB-first bits, stop.
// - Variable modes pick reload generator or timer overflow.
// - Buffer write starts a frame, LSB first.
// - Transmit done flag set at stop start.
// - Enabled receiver starts on falling edge, flags mid-stop.
// - 8-bit mode stores data and stop bit.
// - Fixed 9-bit rate is clock/64 or clock/32.
// - 9-bit frames; ninth sent from txNinth.
// - 9-bit receive stores low byte and ninth bit.
// - Mode 3 uses mode 1 baud selection.
// - Multiproc mode flags only ninth-bit-one frames.
// - Reload rate: doubled clock over 64*(1024-reload).
// - Timer rate: doubled over 32 overflow periods.
// - Disabled unit halts clocks, locks its registers.
// - Gated requests share one vector, 0x0023.
// - Transmit pin only pulled low; output latch held low.
package uart_pkg;
  // Bus geometry; a register index sits in paddr[11:2].
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;
  localparam logic [IDX_W-1:0] IDX_PWR  = 10'h087;
  localparam logic [IDX_W-1:0] IDX_SCON = 10'h098;
  localparam logic [IDX_W-1:0] IDX_SBUF = 10'h099;
  localparam logic [IDX_W-1:0] IDX_INTE = 10'h0A8;
  localparam logic [IDX_W-1:0] IDX_BSRC = 10'h0D8;
  localparam logic [IDX_W-1:0] IDX_RELH = 10'h0DA;
  localparam logic [IDX_W-1:0] IDX_RELL = 10'h0DB;

  // Field positions.
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MP      = 5;
  localparam int SC_EN      = 4;
  localparam int SC_TB8     = 3;
  localparam int SC_RB8     = 2;
  localparam int SC_TI      = 1;
  localparam int SC_RI      = 0;
  localparam int BSRC_SEL   = 7;
  localparam int PWR_DBL    = 7;
  localparam int IEN_GLB    = 7;
  localparam int IEN_ES     = 4;
  localparam int RELH_W     = 2;

  // Reset values.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] RELH_RST = 2'h0;

  // Baud and bit timing.
  localparam logic [9:0] RELOAD_LAST = 10'h3FF;
  localparam logic [1:0] DIV_CPU_SLOW = 2'h3;
  localparam logic [1:0] DIV_CPU_FAST = 2'h1;
  localparam logic [1:0] DIV_T1_SLOW  = 2'h1;
  localparam logic [1:0] DIV_T1_FAST  = 2'h0;
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] OVS_MID   = 4'h7;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;

  localparam logic [15:0] IRQ_VECTOR = 16'h0023;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8VAR  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } frame_mode_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_START = 2'b01,
    S_DATA  = 2'b11,
    S_STOP  = 2'b10
  } line_state_t;
endpackage

/* uart_baud_if.sv */
// Baud configuration toward the generator and its oversample tick back.
interface uart_baud_if;
  logic       enable;
  logic       fixedRate;
  logic       useReload;
  logic       doubler;
  logic [9:0] reloadValue;
  logic       t1Overflow;
  logic       tick;
  modport gen (input enable, fixedRate, useReload, doubler, reloadValue,
               input t1Overflow, output tick);
  modport user (output enable, fixedRate, useReload, doubler, reloadValue,
                output t1Overflow, input tick);
endinterface

/* serial_baud_gen.sv */
// Produces a tick at sixteen times the bit rate.
module serial_baud_gen import uart_pkg::*; (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Configuration and tick
  uart_baud_if.gen  b
);
  logic [9:0] baseCnt, next_baseCnt;
  logic [1:0] divCnt, next_divCnt;
  logic       tick, next_tick;
  logic       base;
  logic [1:0] divLast;

  assign b.tick = tick;

  // Base pulse source and divider; a disabled unit holds the count at the reload value.
  always_comb begin
    next_baseCnt = baseCnt;
    next_divCnt = divCnt;
    next_tick = 1'b0;
    base = 1'b0;
    if (baseCnt == RELOAD_LAST) begin
      next_baseCnt = b.reloadValue;
    end else begin
      next_baseCnt = baseCnt + 10'h001;
    end
    if (b.fixedRate) begin
      base = 1'b1;
    end else if (b.useReload) begin
      base = (baseCnt == RELOAD_LAST);
    end else begin
      base = b.t1Overflow;
    end
    if (b.fixedRate || b.useReload) begin
      divLast = b.doubler ? DIV_CPU_FAST : DIV_CPU_SLOW;
    end else begin
      divLast = b.doubler ? DIV_T1_FAST : DIV_T1_SLOW;
    end
    if (base) begin
      if (divCnt >= divLast) begin
        next_divCnt = 2'h0;
        next_tick = 1'b1;
      end else begin
        next_divCnt = divCnt + 2'h1;
      end
    end
    if (!b.enable) begin
      next_baseCnt = b.reloadValue;
      next_divCnt = 2'h0;
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      baseCnt <= 10'h000;
      divCnt <= 2'h0;
      tick <= 1'b0;
    end else begin
      baseCnt <= next_baseCnt;
      divCnt <= next_divCnt;
      tick <= next_tick;
    end
  end

  logic slowFix;
  assign slowFix = b.enable && b.fixedRate && !b.doubler;

  AST_FIXED_SLOW: assert property (@(posedge sys_clk) disable iff (rst)
    tick && slowFix |=> (!tick[*3] ##1 tick) or (##[0:3] !slowFix))
    else $error("Fixed slow rate tick not every four clocks.");
endmodule // serial_baud_gen

/* async_serial_uart.sv */
// Asynchronous serial unit, modes 1 to 3, with an APB register slave.
module async_serial_uart import uart_pkg::*; (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Serial pins
  input  wire logic              rxPin,
  output logic                   txPinOut,
  output logic                   txPinOe,
  // Timer overflow pulse
  input  wire logic              t1Overflow,
  // Interrupt request
  output logic                   serialIrq,
  output logic      [15:0]       irqVector
);
  frame_mode_t mode, next_mode;
  logic mpEn, next_mpEn, unitEnable, next_unitEnable;
  logic txNinth, next_txNinth, rxNinth, next_rxNinth;
  logic txDone, next_txDone, rxDone, next_rxDone;
  logic baudSel, next_baudSel, doubler, next_doubler;
  logic globalEn, next_globalEn, es, next_es;
  logic [RELH_W-1:0] relH, next_relH;
  logic [7:0] relL, next_relL, rxBuf, next_rxBuf;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic wrEn, txStart, nine, txSetDone, rxSample, rxStore;
  logic mpBlock, rxNinthGot;
  logic [7:0] rv, rxData;
  logic [3:0] lastBit;
  line_state_t txState, next_txState, rxState, next_rxState;
  logic [8:0] txShift, next_txShift, rxShift, next_rxShift;
  logic [3:0] txBit, next_txBit, txTick, next_txTick;
  logic [3:0] rxBit, next_rxBit, rxTick, next_rxTick;
  logic next_txPinOe, rxSync1, rxSync2, rxPrev;
  logic next_serialIrq;
  logic [15:0] next_irqVector;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [IDX_W-1:0] idx);
    hit = (a[ADDR_W-1:2] == idx);
  endfunction

  // Baud generator runs only while the unit is enabled.
  uart_baud_if bIf ();
  assign bIf.enable = unitEnable;
  assign bIf.fixedRate = (mode == MODE_9FIX);
  assign bIf.useReload = baudSel;
  assign bIf.doubler = doubler;
  assign bIf.reloadValue = {relH, relL};
  assign bIf.t1Overflow = t1Overflow;

  serial_baud_gen uGen (
    .sys_clk (sys_clk),
    .rst     (rst),
    .b       (bIf.gen)
  );

  assign nine = mode[1];
  assign lastBit = nine ? LAST_BIT9 : LAST_BIT8;
  assign wrEn = psel && penable && pready && pwrite;
  assign txStart = wrEn && hit(paddr, IDX_SBUF) && unitEnable &&
                   (mode != MODE_SHIFT);

  // APB answer: one wait state, read data and error registered.
  always_comb begin
    next_pready = psel && penable && !pready;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    rv = BYTE_RST;
    if (hit(paddr, IDX_SCON)) begin
      rv = {mode, mpEn, unitEnable, txNinth, rxNinth, txDone, rxDone};
    end else if (hit(paddr, IDX_SBUF)) begin
      rv = rxBuf;
    end else if (hit(paddr, IDX_PWR)) begin
      rv[PWR_DBL] = doubler;
    end else if (hit(paddr, IDX_BSRC)) begin
      rv[BSRC_SEL] = baudSel;
    end else if (hit(paddr, IDX_RELH)) begin
      rv[RELH_W-1:0] = relH;
    end else if (hit(paddr, IDX_RELL)) begin
      rv = relL;
    end else if (!hit(paddr, IDX_INTE)) begin
      next_pslverr = next_pready;
    end
    if (!unitEnable && !hit(paddr, IDX_INTE)) begin
      rv = BYTE_RST;
    end
    if (hit(paddr, IDX_INTE)) begin
      rv[IEN_GLB] = globalEn;
      rv[IEN_ES] = es;
    end
    if (next_pready && !pwrite) begin
      next_prdata[7:0] = rv;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Register file; hardware flag sets win over a same-cycle clear.
  always_comb begin
    next_mode = mode;
    next_mpEn = mpEn;
    next_unitEnable = unitEnable;
    next_txNinth = txNinth;
    next_rxNinth = rxNinth;
    next_txDone = txDone;
    next_rxDone = rxDone;
    next_baudSel = baudSel;
    next_doubler = doubler;
    next_relH = relH;
    next_relL = relL;
    next_rxBuf = rxBuf;
    next_globalEn = globalEn;
    next_es = es;
    if (wrEn && hit(paddr, IDX_SCON)) begin
      next_unitEnable = pwdata[SC_EN];
    end
    if (wrEn && unitEnable) begin
      if (hit(paddr, IDX_SCON)) begin
        next_mode = frame_mode_t'(pwdata[SC_MODE_HI:SC_MODE_LO]);
        next_mpEn = pwdata[SC_MP];
        next_txNinth = pwdata[SC_TB8];
        next_rxNinth = pwdata[SC_RB8];
        next_txDone = pwdata[SC_TI];
        next_rxDone = pwdata[SC_RI];
      end
      if (hit(paddr, IDX_PWR)) begin
        next_doubler = pwdata[PWR_DBL];
      end
      if (hit(paddr, IDX_BSRC)) begin
        next_baudSel = pwdata[BSRC_SEL];
      end
      if (hit(paddr, IDX_RELH)) begin
        next_relH = pwdata[RELH_W-1:0];
      end
      if (hit(paddr, IDX_RELL)) begin
        next_relL = pwdata[7:0];
      end
    end
    if (wrEn && hit(paddr, IDX_INTE)) begin
      next_globalEn = pwdata[IEN_GLB];
      next_es = pwdata[IEN_ES];
    end
    if (txSetDone) begin
      next_txDone = 1'b1;
    end
    if (rxStore) begin
      next_rxDone = 1'b1;
      next_rxBuf = rxData;
      next_rxNinth = rxNinthGot;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode <= MODE_SHIFT;
      {mpEn, unitEnable, txNinth, rxNinth} <= 4'h0;
      {txDone, rxDone, baudSel, doubler, globalEn, es} <= 6'h00;
      relH <= RELH_RST;
      relL <= BYTE_RST;
      rxBuf <= BYTE_RST;
    end else begin
      mode <= next_mode;
      mpEn <= next_mpEn;
      unitEnable <= next_unitEnable;
      txNinth <= next_txNinth;
      rxNinth <= next_rxNinth;
      txDone <= next_txDone;
      rxDone <= next_rxDone;
      baudSel <= next_baudSel;
      doubler <= next_doubler;
      relH <= next_relH;
      relL <= next_relL;
      rxBuf <= next_rxBuf;
      globalEn <= next_globalEn;
      es <= next_es;
    end
  end

  // Transmitter; a write while busy is ignored rather than corrupting.
  always_comb begin
    next_txState = txState;
    next_txShift = txShift;
    next_txBit = txBit;
    next_txTick = txTick;
    txSetDone = 1'b0;
    case (txState)
      S_IDLE: begin
        if (txStart) begin
          next_txShift = {txNinth, pwdata[7:0]};
          next_txBit = 4'h0;
          next_txTick = 4'h0;
          next_txState = S_START;
        end
      end
      default: begin
        if (bIf.tick) begin
          next_txTick = txTick + 4'h1;
          if (txTick == OVS_LAST) begin
            case (txState)
              S_START: next_txState = S_DATA;
              S_DATA: begin
                next_txShift = {1'b0, txShift[8:1]};
                next_txBit = txBit + 4'h1;
                if (txBit == lastBit) begin
                  next_txState = S_STOP;
                  txSetDone = 1'b1;
                end
              end
              default: next_txState = S_IDLE;
            endcase
          end
        end
      end
    endcase
    if (!unitEnable) begin
      next_txState = S_IDLE;
      txSetDone = 1'b0;
    end
    next_txPinOe = (next_txState == S_START) ||
                   ((next_txState == S_DATA) && !next_txShift[0]);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txState <= S_IDLE;
      txShift <= 9'h000;
      txBit <= 4'h0;
      txTick <= 4'h0;
      txPinOe <= 1'b0;
      txPinOut <= 1'b0;
    end else begin
      txState <= next_txState;
      txShift <= next_txShift;
      txBit <= next_txBit;
      txTick <= next_txTick;
      txPinOe <= next_txPinOe;
      txPinOut <= 1'b0;
    end
  end

  // The pin is asynchronous; only the second stage and the third stage (rxPrev, for edge detection) feed logic.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {rxSync1, rxSync2, rxPrev} <= 3'h7;
    end else begin
      rxSync1 <= rxPin;
      rxSync2 <= rxSync1;
      rxPrev <= rxSync2;
    end
  end

  assign rxSample = (rxState == S_STOP) && bIf.tick && (rxTick == OVS_LAST);
  assign rxData = nine ? rxShift[7:0] : rxShift[8:1];
  assign rxNinthGot = nine ? rxShift[8] : rxSync2;
  assign mpBlock = nine && mpEn && !rxNinthGot;
  assign rxStore = rxSample && !mpBlock;

  // Receiver; a start bit still high at its middle counts as noise.
  always_comb begin
    next_rxState = rxState;
    next_rxShift = rxShift;
    next_rxBit = rxBit;
    next_rxTick = rxTick;
    case (rxState)
      S_IDLE: begin
        if (rxPrev && !rxSync2 && (mode != MODE_SHIFT)) begin
          next_rxTick = 4'h0;
          next_rxBit = 4'h0;
          next_rxState = S_START;
        end
      end
      S_START: begin
        if (bIf.tick) begin
          next_rxTick = rxTick + 4'h1;
          if (rxTick == OVS_MID) begin
            next_rxTick = 4'h0;
            next_rxState = rxSync2 ? S_IDLE : S_DATA;
          end
        end
      end
      S_DATA: begin
        if (bIf.tick) begin
          next_rxTick = rxTick + 4'h1;
          if (rxTick == OVS_LAST) begin
            next_rxShift = {rxSync2, rxShift[8:1]};
            next_rxBit = rxBit + 4'h1;
            if (rxBit == lastBit) begin
              next_rxState = S_STOP;
            end
          end
        end
      end
      default: begin
        if (bIf.tick) begin
          next_rxTick = rxTick + 4'h1;
        end
        if (rxSample) begin
          next_rxState = S_IDLE;
        end
      end
    endcase
    if (!unitEnable) begin
      next_rxState = S_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxState <= S_IDLE;
      rxShift <= 9'h000;
      rxBit <= 4'h0;
      rxTick <= 4'h0;
    end else begin
      rxState <= next_rxState;
      rxShift <= next_rxShift;
      rxBit <= next_rxBit;
      rxTick <= next_rxTick;
    end
  end

  // Interrupt request and vector.
  always_comb begin
    next_serialIrq = globalEn && es && (txDone || rxDone);
    next_irqVector = next_serialIrq ? IRQ_VECTOR : 16'h0000;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serialIrq <= 1'b0;
      irqVector <= 16'h0000;
    end else begin
      serialIrq <= next_serialIrq;
      irqVector <= next_irqVector;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence stopEnd;
    rxState == S_STOP && bIf.tick && rxTick == OVS_LAST;
  endsequence

  AST_TX_IDLE_HIGH: assert property (
    txState == S_IDLE |-> !txPinOe)
    else $error("Transmit line driven low while idle.");
  AST_TX_START: assert property (
    txStart && txState == S_IDLE |=> txState == S_START && txPinOe)
    else $error("Buffer write did not start a frame.");
  AST_TX_DONE: assert property (
    txState == S_DATA ##1 txState == S_STOP |-> txDone)
    else $error("Transmit flag not set at stop bit.");
  AST_TX_BIT: assert property (
    txState == S_DATA |-> txPinOe == !txShift[0])
    else $error("Data bit on the pin differs from shifter.");
  AST_RX_DONE: assert property (
    stopEnd ##0 !mpBlock |=> rxDone && rxState == S_IDLE)
    else $error("Receive flag not set in stop bit.");
  AST_MP_BLOCK: assert property (
    stopEnd ##0 mpBlock |=> !$rose(rxDone) && $stable(rxBuf))
    else $error("Filtered frame raised a receive flag.");
  AST_RX_STORE: assert property (
    stopEnd ##0 !mpBlock |=> rxNinth == $past(rxNinthGot) &&
      rxBuf == $past(rxData))
    else $error("Received data not stored.");
  AST_LOCKED: assert property (
    !unitEnable && wrEn && hit(paddr, IDX_RELL) |=> $stable(relL))
    else $error("Locked register accepted a write.");
  AST_IRQ: assert property (
    globalEn && es && rxDone |=> serialIrq && irqVector == IRQ_VECTOR)
    else $error("Interrupt request missing.");
endmodule // async_serial_uart

/* remote_uart.sv */
// Remote serial station facing the unit's transmit and receive lines.
module remote_uart (
  // Clock
  input  wire logic sys_clk,
  // Line levels
  input  wire logic txLine,
  output logic      rxLine
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line rests high between frames, as an idle sender leaves it.
  initial rxLine = 1'h1;

  // Start bit, then nBits data bits LSB first, then one stop bit.
  // frame layout
  task automatic send_frame(input logic [8:0] data, input int nBits,
                            input int period);
    int i;
    rxLine <= 1'h0;
    repeat (period) @(posedge sys_clk);
    for (i = 0; i < nBits; i++) begin
      rxLine <= data[i];
      repeat (period) @(posedge sys_clk);
    end
    rxLine <= 1'h1;
    repeat (period + 4) @(posedge sys_clk);
  endtask

  // Samples mid-bit from the start edge, so a slightly short start is fine.
  // frame layout
  task automatic recv_frame(input int nBits, input int period,
                            output logic [8:0] data, output logic stopBit);
    int i;
    data = 9'h000;
    @(negedge txLine);
    repeat (period / 2) @(posedge sys_clk);
    for (i = 0; i < nBits; i++) begin
      repeat (period) @(posedge sys_clk);
      data[i] = txLine;
    end
    repeat (period) @(posedge sys_clk);
    stopBit = txLine;
  endtask
endmodule // remote_uart

/* async_serial_uart_tb.sv */
// Self-checking bench for the serial unit.
module async_serial_uart_tb;
  import uart_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              rxLine;
  logic              txPinOut;
  logic              txPinOe;
  logic              txLine;
  logic              t1Overflow = 1'h0;
  logic [2:0]        ovfCount = 3'h0;
  logic              serialIrq;
  logic [15:0]       irqVector;
  logic [8:0]        got;
  logic              stopBit;
  int                mismatches;
  int                samplesChecked;

  // The pin has a pull-up; the unit only ever pulls it low.
  // pull-up line
  assign txLine = txPinOe ? txPinOut : 1'h1;

  async_serial_uart dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxPin(rxLine),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .t1Overflow(t1Overflow),
    .serialIrq(serialIrq), .irqVector(irqVector)
  );

  remote_uart partner (.sys_clk(sys_clk), .txLine(txLine), .rxLine(rxLine));

  always #10 sys_clk = ~sys_clk;

  // Overflow every fifth cycle keeps the clock above four times its rate.
  // timer pacing
  always @(posedge sys_clk) begin
    if (ovfCount == 3'h4) begin
      ovfCount   <= 3'h0;
      t1Overflow <= 1'h1;
    end else begin
      ovfCount   <= ovfCount + 3'h1;
      t1Overflow <= 1'h0;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h000000, wd};
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    // Only the watchdog ends a wait that never sees pready.
    while (pready !== 1'h1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'h1, idx, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'h0, idx, 8'h00, rd, err);
    chk({err, rd[30:0]}, {24'h000000, exp}, "register read");
  endtask

  task automatic report_and_stop();
    $display("Checked %0d, mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset values, locking while disabled, and an unmapped address.
  task automatic test_regs();
    logic [31:0] rd;
    logic        err;
    wr(IDX_SBUF, 8'h5A);
    wr(IDX_PWR, 8'h80);
    wr(IDX_RELL, 8'h5A);
    repeat (8) @(posedge sys_clk);
    chk({31'h0, txPinOe}, 32'h0, "no frame when off");
    rd_chk(IDX_SCON, 8'h00);
    rd_chk(IDX_INTE, 8'h00);
    wr(IDX_SCON, 8'h10);
    rd_chk(IDX_PWR, 8'h00);
    rd_chk(IDX_RELL, 8'h00);
    rd_chk(IDX_SBUF, 8'h00);
    rd_chk(IDX_SCON, 8'h10);
    apb(1'h0, 10'h001, 8'h00, rd, err);
    chk({31'h0, err}, 32'h1, "unmapped error");
  endtask

  // Fixed-rate nine-bit transmit with the ninth bit set.
  task automatic test_mode2_tx();
    wr(IDX_INTE, 8'h90);
    wr(IDX_SCON, 8'h98);
    fork
      partner.recv_frame(9, 64, got, stopBit);
      wr(IDX_SBUF, 8'hA5);
    join
    chk({23'h0, got}, 32'h1A5, "mode 2 frame");
    chk({31'h0, stopBit}, 32'h1, "stop level");
    chk({15'h0, serialIrq, irqVector}, 32'h10023, "irq");
    rd_chk(IDX_SCON, 8'h9A);
    wr(IDX_SCON, 8'h98);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, serialIrq}, 32'h0, "irq cleared");
    chk({31'h0, txPinOe}, 32'h0, "idle high");
  endtask

  // Reload generator, doubled, reload 0x3FD gives a 96-cycle bit.
  task automatic test_mode1_reload();
    wr(IDX_PWR, 8'h80);
    wr(IDX_BSRC, 8'h80);
    wr(IDX_RELH, 8'h03);
    wr(IDX_RELL, 8'hFD);
    wr(IDX_SCON, 8'h50);
    // The reload counter takes a new value only when it wraps, so let
    // one full count pass before the first frame relies on the rate.
    repeat (1030) @(posedge sys_clk);
    partner.send_frame(9'h03C, 8, 96);
    rd_chk(IDX_SBUF, 8'h3C);
    rd_chk(IDX_SCON, 8'h55);
    fork
      partner.recv_frame(8, 96, got, stopBit);
      wr(IDX_SBUF, 8'h81);
    join
    chk({23'h0, got}, 32'h081, "mode 1 frame");
    chk({31'h0, stopBit}, 32'h1, "stop level");
  endtask

  // Timer overflow rate, doubled: 16 overflows of 5 cycles per bit.
  task automatic test_mode3_mp();
    wr(IDX_BSRC, 8'h00);
    wr(IDX_SCON, 8'hF0);
    partner.send_frame(9'h055, 9, 80);
    rd_chk(IDX_SCON, 8'hF0);
    partner.send_frame(9'h112, 9, 80);
    rd_chk(IDX_SCON, 8'hF5);
    rd_chk(IDX_SBUF, 8'h12);
    wr(IDX_SCON, 8'hD0);
    partner.send_frame(9'h077, 9, 80);
    rd_chk(IDX_SCON, 8'hD1);
    rd_chk(IDX_SBUF, 8'h77);
  endtask

  // Main sequence.
  initial begin
    sys_clk = 1'h0;
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = 32'h00000000;
    mismatches = 0;
    samplesChecked = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    test_regs();
    test_mode2_tx();
    test_mode1_reload();
    test_mode3_mp();
    report_and_stop();
  end

  // Watchdog; the whole run needs about a third of this.
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule // async_serial_uart_tb
